// ===== src/hpdcs_consts.vh
// constants for the headphone dc servo start-up control block
// Behaviour
// - bit 1 enables left servo, bit 0 enables right servo.
// - start-up trigger (bit 5 left, bit 4 right) runs measure-correct series.
// - start-up trigger bit reads 1 while that series runs.
// - series ends within 1mV of ground, about 25ms per channel.
// - preset trigger (bit 3 left, bit 2 right) loads preset word, no measuring.
// - preset load completes in about 2ms per channel.
// - preset trigger bit reads 1 while that load runs.
// - preset words 8-bit two's complement, left 15:8, right 7:0, 0.25mV step.
// - start-up done status in bits 1:0, bit 1 left, bit 0 right.
// - preset done status in bits 5:4, bit 5 left, bit 4 right.
// - bits 9:8 are bitwise OR of start-up and preset done.
// - correction is held on each channel after a series finishes.
`ifndef HPDCS_CONSTS_VH
`define HPDCS_CONSTS_VH
// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define HPDCS_REG_TRIG      8'h54
`define HPDCS_REG_PRESET    8'h57
`define HPDCS_REG_STATUS    8'h58
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define HPDCS_ENA_R         0
`define HPDCS_ENA_L         1
`define HPDCS_LOAD_R        2
`define HPDCS_LOAD_L        3
`define HPDCS_MEAS_R        4
`define HPDCS_MEAS_L        5
`define HPDCS_PRE_L_HI      15
`define HPDCS_PRE_L_LO      8
`define HPDCS_PRE_R_HI      7
`define HPDCS_PRE_R_LO      0
`define HPDCS_PRESET_RST    16'h0000
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define HPDCS_CLK_MHZ       24'h0000fa
`define HPDCS_MEAS_US       24'h0061a8
`define HPDCS_LOAD_US       24'h0007d0
`define HPDCS_MEAS_CYC      (`HPDCS_MEAS_US * `HPDCS_CLK_MHZ)
`define HPDCS_LOAD_CYC      (`HPDCS_LOAD_US * `HPDCS_CLK_MHZ)
`define HPDCS_STEP_CNT      8'h20
`endif

// ===== src/hpdcs_ctrl.v
// headphone dc servo start-up and preset-load control
`timescale 1ns/1ps
`include "hpdcs_consts.vh"
module hpdcs_ctrl #(
    parameter [23:0] MEAS_CYCLES = `HPDCS_MEAS_CYC,
    parameter [23:0] LOAD_CYCLES = `HPDCS_LOAD_CYC
) (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // register port
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    output reg  [15:0] reg_rdata_o,
    // analogue side: offset compare, high when output above ground
    input  wire        offset_pos_left_i,
    input  wire        offset_pos_right_i,
    // analogue side: correction words and enables
    output reg  [7:0]  corr_word_left_o,
    output reg  [7:0]  corr_word_right_o,
    output wire        servo_on_left_o,
    output wire        servo_on_right_o
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg  [1:0]  servo_on_r;
    reg  [15:0] preset_r;
    reg  [1:0]  meas_busy_r;
    reg  [1:0]  load_busy_r;
    reg  [1:0]  measure_seq_done_r;
    reg  [1:0]  preset_load_done_r;
    reg  [23:0] timer_r [0:1];
    reg  [1:0]  cmp_s1_r;
    reg  [1:0]  cmp_s2_r;

    wire [1:0]  any_correction_done;
    wire        wr_trig;
    wire [1:0]  meas_go;
    wire [1:0]  load_go;
    wire [23:0] meas_step;
    wire [35:0] seq_left_nxt;
    wire [35:0] seq_right_nxt;

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    // accept a trigger only with its enable set and the channel idle
    function [1:0] trig_accept;
        input       wr;
        input [1:0] trig;
        input [1:0] ena;
        input [1:0] busy;
        begin
            trig_accept = {2{wr}} & trig & ena & ~busy;
        end
    endfunction

    // one lsb toward ground, direction from the synced comparator
    function [7:0] step_toward;
        input [7:0] word;
        input       above;
        begin
            if (above)
                step_toward = word - 8'h01;
            else
                step_toward = word + 8'h01;
        end
    endfunction

    // channel next value, packed as {meas busy, load busy,
    // meas done, load done, timer, correction word}
    function [35:0] chan_next;
        input        m_go;
        input        l_go;
        input        m_busy;
        input        l_busy;
        input        m_done;
        input        l_done;
        input [23:0] tmr;
        input [7:0]  word;
        input [7:0]  preset;
        input        above;
        input [23:0] step;
        reg          nb_m;
        reg          nb_l;
        reg          nd_m;
        reg          nd_l;
        reg   [23:0] nt;
        reg   [7:0]  nw;
        begin
            nb_m = m_busy;
            nb_l = l_busy;
            nd_m = m_done;
            nd_l = l_done;
            nt   = tmr;
            nw   = word;
            if (m_go) begin
                nb_m = 1'b1;
                nd_m = 1'b0;
                nt   = MEAS_CYCLES;
            end else if (l_go) begin
                nb_l = 1'b1;
                nd_l = 1'b0;
                nt   = LOAD_CYCLES;
                nw   = preset;
            end else if (m_busy || l_busy) begin
                nt = tmr - 24'h000001;
                if (m_busy && ((tmr % step) == 24'h000000))
                    nw = step_toward(word, above);
                if (tmr == 24'h000001) begin
                    nb_m = 1'b0;
                    nb_l = 1'b0;
                    if (m_busy)
                        nd_m = 1'b1;
                    if (l_busy)
                        nd_l = 1'b1;
                end
            end
            chan_next = {nb_m, nb_l, nd_m, nd_l, nt, nw};
        end
    endfunction

    assign servo_on_left_o  = servo_on_r[1];
    assign servo_on_right_o = servo_on_r[0];

    assign any_correction_done = measure_seq_done_r | preset_load_done_r;

    assign wr_trig = reg_wr_i && (reg_addr_i == `HPDCS_REG_TRIG);
    // ignore trigger on disabled or busy channel
    assign meas_go = trig_accept(wr_trig, reg_wdata_i[`HPDCS_MEAS_L:`HPDCS_MEAS_R],
                                 reg_wdata_i[`HPDCS_ENA_L:`HPDCS_ENA_R],
                                 meas_busy_r | load_busy_r);
    // start-up wins when both kinds are written at once
    assign load_go = trig_accept(wr_trig, reg_wdata_i[`HPDCS_LOAD_L:`HPDCS_LOAD_R],
                                 reg_wdata_i[`HPDCS_ENA_L:`HPDCS_ENA_R],
                                 meas_busy_r | load_busy_r) & ~meas_go;
    // one correction step spacing within the series
    assign meas_step = MEAS_CYCLES / {16'h0000, `HPDCS_STEP_CNT};

    // per-channel next values
    assign seq_left_nxt  = chan_next(meas_go[1], load_go[1], meas_busy_r[1],
                                     load_busy_r[1], measure_seq_done_r[1],
                                     preset_load_done_r[1], timer_r[1], corr_word_left_o,
                                     preset_r[`HPDCS_PRE_L_HI:`HPDCS_PRE_L_LO],
                                     cmp_s2_r[1], meas_step);
    assign seq_right_nxt = chan_next(meas_go[0], load_go[0], meas_busy_r[0],
                                     load_busy_r[0], measure_seq_done_r[0],
                                     preset_load_done_r[0], timer_r[0], corr_word_right_o,
                                     preset_r[`HPDCS_PRE_R_HI:`HPDCS_PRE_R_LO],
                                     cmp_s2_r[0], meas_step);

    // ---------------------------------------------------------------
    // comparator synchronisers
    // ---------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_s1_r <= 2'h0;
            cmp_s2_r <= 2'h0;
        end else begin
            cmp_s1_r <= {offset_pos_left_i, offset_pos_right_i};
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            servo_on_r <= 2'h0;
            preset_r   <= `HPDCS_PRESET_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `HPDCS_REG_TRIG)
                servo_on_r <= reg_wdata_i[`HPDCS_ENA_L:`HPDCS_ENA_R];
            if (reg_addr_i == `HPDCS_REG_PRESET)
                preset_r <= reg_wdata_i;
        end
    end

    // ---------------------------------------------------------------
    // per-channel sequencers
    // ---------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meas_busy_r        <= 2'h0;
            load_busy_r        <= 2'h0;
            measure_seq_done_r <= 2'h0;
            preset_load_done_r <= 2'h0;
            corr_word_left_o   <= 8'h00;
            corr_word_right_o  <= 8'h00;
            timer_r[0]         <= 24'h000000;
            timer_r[1]         <= 24'h000000;
        end else begin
            // left channel
            meas_busy_r[1]        <= seq_left_nxt[35];
            load_busy_r[1]        <= seq_left_nxt[34];
            measure_seq_done_r[1] <= seq_left_nxt[33];
            preset_load_done_r[1] <= seq_left_nxt[32];
            timer_r[1]            <= seq_left_nxt[31:8];
            corr_word_left_o      <= seq_left_nxt[7:0];
            // right channel
            meas_busy_r[0]        <= seq_right_nxt[35];
            load_busy_r[0]        <= seq_right_nxt[34];
            measure_seq_done_r[0] <= seq_right_nxt[33];
            preset_load_done_r[0] <= seq_right_nxt[32];
            timer_r[0]            <= seq_right_nxt[31:8];
            corr_word_right_o     <= seq_right_nxt[7:0];
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `HPDCS_REG_TRIG:   reg_rdata_o <= {10'h000, meas_busy_r, load_busy_r, servo_on_r};
                `HPDCS_REG_PRESET: reg_rdata_o <= preset_r;
                `HPDCS_REG_STATUS: reg_rdata_o <= {6'h00, any_correction_done, 2'h0,
                                                   preset_load_done_r, 2'h0, measure_seq_done_r};
                default:           reg_rdata_o <= 16'h0000;
            endcase
        end
    end

endmodule // hpdcs_ctrl

// ===== sim/hpdcs_ctrl_props.sv
// port-level assertions for the dc servo control block
`timescale 1ns/1ps
module hpdcs_ctrl_props (
    // clock and reset
    input wire        ref_clk_i,
    input wire        rst_i,
    // register port
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    // analogue side
    input wire [7:0]  corr_word_left_o,
    input wire [7:0]  corr_word_right_o,
    input wire        servo_on_left_o,
    input wire        servo_on_right_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    reg  [15:0] pre_r;
    wire        w54 = reg_wr_i && reg_addr_i == 8'h54;
    wire        r54 = reg_rd_i && reg_addr_i == 8'h54;
    wire        r57 = reg_rd_i && reg_addr_i == 8'h57;
    wire        r58 = reg_rd_i && reg_addr_i == 8'h58;
    // mirror of the preset word
    always @(posedge ref_clk_i or posedge rst_i)
        if (rst_i) pre_r <= 16'h0000;
        else if (reg_wr_i && reg_addr_i == 8'h57) pre_r <= reg_wdata_i;
    property p_ena; w54 |=> {servo_on_left_o, servo_on_right_o} == $past(reg_wdata_i[1:0]);
    endproperty
    a_ena: assert property (p_ena) else $error("enable outputs wrong");
    property p_rd_ena; r54 |=> reg_rdata_o[1:0] == $past({servo_on_left_o, servo_on_right_o});
    endproperty
    a_rd_ena: assert property (p_rd_ena) else $error("enable readback wrong");
    property p_rd_pre; r57 |=> reg_rdata_o == $past(pre_r); endproperty
    a_rd_pre: assert property (p_rd_pre) else $error("preset readback wrong");
    property p_or; r58 |=> reg_rdata_o[9:8] == (reg_rdata_o[5:4] | reg_rdata_o[1:0]); endproperty
    a_or: assert property (p_or) else $error("combined status wrong");
    property p_stp_l; $changed(corr_word_left_o) |-> $past(w54) || $past(w54, 2) ||
        (corr_word_left_o - $past(corr_word_left_o)) inside {8'h01, 8'hff}; endproperty
    a_stp_l: assert property (p_stp_l) else $error("left step not one lsb");
    property p_stp_r; $changed(corr_word_right_o) |-> $past(w54) || $past(w54, 2) ||
        (corr_word_right_o - $past(corr_word_right_o)) inside {8'h01, 8'hff}; endproperty
    a_stp_r: assert property (p_stp_r) else $error("right step not one lsb");
    property p_ign_l; w54 && !reg_wdata_i[1] && !servo_on_left_o |=> $stable(corr_word_left_o)[*3];
    endproperty
    a_ign_l: assert property (p_ign_l) else $error("left trigger not ignored");
    property p_ign_r; w54 && !reg_wdata_i[0] && !servo_on_right_o
        |=> $stable(corr_word_right_o)[*3];
    endproperty
    a_ign_r: assert property (p_ign_r) else $error("right trigger not ignored");
endmodule // hpdcs_ctrl_props

// ===== sim/hpdcs_afe_model.sv
// behavioural output stages and offset comparators
`timescale 1ns/1ps
module hpdcs_afe_model #(
    parameter integer OFS_L = -13,
    parameter integer OFS_R = 9
) (
    input  wire [7:0] corr_word_left_i,
    input  wire [7:0] corr_word_right_i,
    output wire       offset_pos_left_o,
    output wire       offset_pos_right_o
);
    // residual level is intrinsic offset plus correction, in lsb
    assign offset_pos_left_o  = $signed(corr_word_left_i) + OFS_L > 0;
    assign offset_pos_right_o = $signed(corr_word_right_i) + OFS_R > 0;
endmodule // hpdcs_afe_model

// ===== sim/hpdcs_ctrl_tb_top.sv
// self-checking bench for the dc servo control block
`timescale 1ns/1ps
module hpdcs_ctrl_tb_top;
    localparam integer MC = 320, LC = 40, OFL = -13, OFR = 9;
    reg         ref_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    reg  [7:0]  reg_addr_i = 8'h00, held, prr;
    reg  [15:0] reg_wdata_i = 16'h0000, pre;
    reg  [31:0] seed = 32'h0000002a;
    wire [15:0] reg_rdata_o;
    wire [7:0]  cw_l, cw_r;
    wire        pos_l, pos_r, on_l, on_r;
    integer     err_total = 0, n_checks = 0, cyc = 0, mdone = 0, ldone = 0, i;
    hpdcs_ctrl #(.MEAS_CYCLES(MC), .LOAD_CYCLES(LC)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .offset_pos_left_i(pos_l),
        .offset_pos_right_i(pos_r), .corr_word_left_o(cw_l), .corr_word_right_o(cw_r),
        .servo_on_left_o(on_l), .servo_on_right_o(on_r));
    // outputs stay muted and shorted in this model
    hpdcs_afe_model #(.OFS_L(OFL), .OFS_R(OFR)) afe (.corr_word_left_i(cw_l),
        .corr_word_right_i(cw_r), .offset_pos_left_o(pos_l), .offset_pos_right_o(pos_r));
    initial forever #2 ref_clk_i = ~ref_clk_i;
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [15:0] st();
        st = ((mdone | ldone) << 8) | (ldone << 4) | mdone;
    endfunction
    task chk(input [15:0] seen, input [15:0] exp, input string nm);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task acc(input w, input [7:0] a, input [15:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
    endtask
    task rchk(input [7:0] a, input [15:0] exp, input string nm);
        acc(1'b0, a, 16'h0000);
        chk(reg_rdata_o, exp, nm);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            end_sim;
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rchk(8'h57, 16'h0000, "preset");
        rchk(8'h58, 16'h0000, "status");
        rchk(8'h55, 16'h0000, "unmapped");
        acc(1'b1, 8'h54, 16'h0028);
        rchk(8'h54, 16'h0000, "ignored");
        acc(1'b1, 8'h54, 16'h0033);
        rchk(8'h54, 16'h0033, "meas_busy");
        chk({on_l, on_r}, 16'h0003, "servo_on");
        acc(1'b1, 8'h54, 16'h003f);
        rchk(8'h54, 16'h0033, "busy_ignore");
        repeat (MC + 40) @(posedge ref_clk_i);
        mdone = 3;
        rchk(8'h54, 16'h0003, "meas_clear");
        rchk(8'h58, st(), "meas_done");
        chk(($signed(cw_l) + OFL) inside {[-4:4]}, 16'h0001, "resid_l");
        chk(($signed(cw_r) + OFR) inside {[-4:4]}, 16'h0001, "resid_r");
        held = cw_l;
        repeat (60) @(posedge ref_clk_i);
        chk(cw_l, held, "held_l");
        for (i = 0; i < 2; i = i + 1) begin
            seed = xs(seed);
            pre = seed[15:0];
            prr = i ? prr : pre[7:0];
            ldone = i ? 1 : 0;
            acc(1'b1, 8'h57, pre);
            acc(1'b1, 8'h54, i ? 16'h000b : 16'h000f);
            rchk(8'h54, i ? 16'h000b : 16'h000f, "load_busy");
            rchk(8'h58, st(), "load_start");
            chk({cw_l, cw_r}, {pre[15:8], prr}, "corr_word");
            repeat (LC + 20) @(posedge ref_clk_i);
            ldone = 3;
            rchk(8'h58, st(), "load_done");
            rchk(8'h57, pre, "preset_rb");
        end
        acc(1'b1, 8'h54, 16'h002a);
        mdone = 1;
        rchk(8'h54, 16'h0022, "meas_wins");
        rchk(8'h58, st(), "meas_restart");
        chk({on_l, on_r}, 16'h0002, "servo_on_l");
        repeat (MC + 40) @(posedge ref_clk_i);
        mdone = 3;
        rchk(8'h58, st(), "meas_redone");
        end_sim;
    end
endmodule // hpdcs_ctrl_tb_top
bind hpdcs_ctrl hpdcs_ctrl_props chk_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .corr_word_left_o(corr_word_left_o),
    .corr_word_right_o(corr_word_right_o), .servo_on_left_o(servo_on_left_o),
    .servo_on_right_o(servo_on_right_o));
